// ### rtl/logic_cell_input_gating.sv
// Purpose: Input selection and gating stage of a configurable logic cell
// Assumes: Avalon-MM slave, word addressed, byte registers in low bits
// Notes: Selector and mask registers have no reset
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module logic_cell_input_gating (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Avalon-MM slave
    input wire logic [cell_gate_pkg::ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // Source signals
    input wire logic [cell_gate_pkg::SRC_W-1:0] sources_in,
    // Cell data and gate outputs
    output logic cell_data_in_a_out,
    output logic cell_data_in_b_out,
    output logic cell_data_in_c_out,
    output logic cell_data_in_d_out,
    output logic gate0_out,
    output logic gate1_out
);
    import cell_gate_pkg::*;

    // Selector and mask storage, no reset: contents undefined until written
    logic [SEL_W-1:0] source_code_ff [NUM_DATA];
    logic [SEL_W-1:0] nxt_source_code [NUM_DATA];
    logic [7:0] gate0_term_mask_ff;
    logic [7:0] gate1_term_mask_ff;
    logic [7:0] nxt_gate0_term_mask;
    logic [7:0] nxt_gate1_term_mask;
    logic [7:0] control_ff;
    logic [7:0] nxt_control;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic ack_ff;
    logic nxt_ack;
    logic [NUM_DATA-1:0] data_ff;
    logic [NUM_DATA-1:0] nxt_data;
    logic [1:0] gate_ff;
    logic [1:0] nxt_gate;
    logic [1:0] raw_gate;
    logic wr_en;
    logic [7:0] wbyte;

    // One wait state: request accepted on the cycle ack_ff is high
    assign waitrequest_out = (read_in | write_in) & ~ack_ff;
    assign wr_en = write_in & ack_ff & byteenable_in[0];
    assign wbyte = writedata_in[7:0];

    always_comb begin
        nxt_ack = (read_in | write_in) & ~ack_ff;
        nxt_readdata = readdata_ff;
        if (read_in & ~ack_ff) begin
            nxt_readdata = UNMAPPED_READ;
            unique case (address_in)
                DATA1_SEL_IDX: nxt_readdata = {26'h0, source_code_ff[0]};
                DATA2_SEL_IDX: nxt_readdata = {26'h0, source_code_ff[1]};
                DATA3_SEL_IDX: nxt_readdata = {26'h0, source_code_ff[2]};
                DATA4_SEL_IDX: nxt_readdata = {26'h0, source_code_ff[3]};
                GATE0_MASK_IDX: nxt_readdata = {24'h0, gate0_term_mask_ff};
                GATE1_MASK_IDX: nxt_readdata = {24'h0, gate1_term_mask_ff};
                CONTROL_IDX: nxt_readdata = {24'h0, control_ff & CTRL_WMASK};
                default: nxt_readdata = UNMAPPED_READ;
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_DATA; i++) begin
            nxt_source_code[i] = source_code_ff[i];
        end
        nxt_gate0_term_mask = gate0_term_mask_ff;
        nxt_gate1_term_mask = gate1_term_mask_ff;
        nxt_control = control_ff;
        if (wr_en) begin
            unique case (address_in)
                DATA1_SEL_IDX: nxt_source_code[0] = wbyte[SEL_W-1:0];
                DATA2_SEL_IDX: nxt_source_code[1] = wbyte[SEL_W-1:0];
                DATA3_SEL_IDX: nxt_source_code[2] = wbyte[SEL_W-1:0];
                DATA4_SEL_IDX: nxt_source_code[3] = wbyte[SEL_W-1:0];
                GATE0_MASK_IDX: nxt_gate0_term_mask = wbyte;
                GATE1_MASK_IDX: nxt_gate1_term_mask = wbyte;
                CONTROL_IDX: nxt_control = wbyte & CTRL_WMASK;
                default: nxt_control = control_ff;
            endcase
        end
    end

    // selector and mask configuration kept across reset, undefined at power-up
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NUM_DATA; i++) begin
            source_code_ff[i] <= nxt_source_code[i];
        end
        gate0_term_mask_ff <= nxt_gate0_term_mask;
        gate1_term_mask_ff <= nxt_gate1_term_mask;
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            control_ff <= CTRL_RESET;
            readdata_ff <= UNMAPPED_READ;
            ack_ff <= 1'b0;
            data_ff <= '0;
            gate_ff <= '0;
        end else begin
            control_ff <= nxt_control;
            readdata_ff <= nxt_readdata;
            ack_ff <= nxt_ack;
            data_ff <= nxt_data;
            gate_ff <= nxt_gate;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_DATA; i++) begin
            // source code picks the data input
            nxt_data[i] = sources_in[source_code_ff[i]];
        end
    end

    gate_term_or u_gate0 (
        .mask_in(gate0_term_mask_ff),
        .data_in(data_ff),
        .gate_out(raw_gate[0])
    );

    gate_term_or u_gate1 (
        .mask_in(gate1_term_mask_ff),
        .data_in(data_ff),
        .gate_out(raw_gate[1])
    );

    always_comb begin
        nxt_gate[0] = raw_gate[0] ^ control_ff[CTRL_G0_INV_BIT];
        nxt_gate[1] = raw_gate[1] ^ control_ff[CTRL_G1_INV_BIT];
        if (!control_ff[CTRL_ENABLE_BIT]) begin
            nxt_gate = 2'b00;
        end
    end

    assign readdata_out = readdata_ff;
    assign cell_data_in_a_out = data_ff[0];
    assign cell_data_in_b_out = data_ff[1];
    assign cell_data_in_c_out = data_ff[2];
    assign cell_data_in_d_out = data_ff[3];
    assign gate0_out = gate_ff[0];
    assign gate1_out = gate_ff[1];
endmodule : logic_cell_input_gating

// ### rtl/cell_gate_pkg.sv
// Purpose: Constants for the logic cell input gating stage
// Assumes: Byte-wide registers, one per aligned 32-bit word
// Notes: Offsets are word indices on the register bus
package cell_gate_pkg;
    localparam int ADDR_W = 4;
    localparam int SEL_W = 6;
    localparam int NUM_DATA = 4;
    localparam int SRC_W = 64;
    localparam logic [ADDR_W-1:0] DATA1_SEL_IDX = 4'h0;
    localparam logic [ADDR_W-1:0] DATA2_SEL_IDX = 4'h1;
    localparam logic [ADDR_W-1:0] DATA3_SEL_IDX = 4'h2;
    localparam logic [ADDR_W-1:0] DATA4_SEL_IDX = 4'h3;
    localparam logic [ADDR_W-1:0] GATE0_MASK_IDX = 4'h4;
    localparam logic [ADDR_W-1:0] GATE1_MASK_IDX = 4'h5;
    localparam logic [ADDR_W-1:0] CONTROL_IDX = 4'h6;
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_G1_INV_BIT = 1;
    localparam int CTRL_G0_INV_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h83;
    localparam logic [7:0] SEL_WMASK = 8'h3f;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : cell_gate_pkg

// ### rtl/gate_term_or.sv
// Purpose: One data gate, OR of masked true and inverted data terms
// Assumes: Mask bit 2k+1 takes data k true, bit 2k takes data k inverted
// Notes: Pure combinational
`timescale 1ns/1ps
module gate_term_or (
    // Terms
    input wire logic [7:0] mask_in,
    input wire logic [cell_gate_pkg::NUM_DATA-1:0] data_in,
    // Result
    output logic gate_out
);
    import cell_gate_pkg::*;
    logic [7:0] terms;
    genvar k;
    generate
        for (k = 0; k < NUM_DATA; k++) begin : g_term
            assign terms[2*k+1] = mask_in[2*k+1] & data_in[k];
            assign terms[2*k] = mask_in[2*k] & ~data_in[k];
        end
    endgenerate
    assign gate_out = |terms;
endmodule : gate_term_or

// ### verif/cell_gate_assertions.sv
// Purpose: Bus timing and readback checks
// Assumes: One clock domain
// Notes: Attached by bind
`timescale 1ns/1ps
module cell_gate_checker (
    // Watched ports
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [cell_gate_pkg::ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire logic gate0_out,
    input wire logic gate1_out
);
    import cell_gate_pkg::*;
    logic rd_ok;
    assign rd_ok = read_in && !waitrequest_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    a_wait_first: assert property ($rose(read_in || write_in) |-> waitrequest_out) else $error("no wait");
    a_wait_one: assert property (waitrequest_out |=> !waitrequest_out) else $error("long wait");
    a_idle_ready: assert property (!(read_in || write_in) |-> !waitrequest_out) else $error("idle wait");
    a_sel_upper: assert property (
        rd_ok && address_in < GATE0_MASK_IDX |-> readdata_out[31:6] == 26'h0) else $error("sel bits");
    a_ctrl_bits: assert property (rd_ok && address_in == CONTROL_IDX |-> (readdata_out & ~32'h83) == 32'h0)
        else $error("ctrl bits");
    a_unmapped_zero: assert property (rd_ok && address_in > CONTROL_IDX |-> readdata_out == UNMAPPED_READ)
        else $error("unmapped");
    a_rdata_hold: assert property (!(read_in && waitrequest_out) |=> $stable(readdata_out)) else $error("rdata moved");
    a_gate_reset: assert property ($rose(resetn_in) |-> !gate0_out && !gate1_out) else $error("gate on");
    c_read: cover property (rd_ok);
    c_write: cover property (write_in && !waitrequest_out);
    c_gates: cover property (gate0_out && gate1_out);
endmodule : cell_gate_checker

bind logic_cell_input_gating cell_gate_checker i_chk (.clock_in, .resetn_in, .address_in, .read_in,
    .write_in, .readdata_out, .waitrequest_out, .gate0_out, .gate1_out);

// ### verif/sources_model.sv
// Purpose: Source signal model
// Assumes: Selector codes 63, 32, 17, 5
// Notes: Other slots hold a fixed pattern
`timescale 1ns/1ps
module sources_model (
    // Levels and sources
    input wire logic [3:0] level_in,
    output logic [63:0] sources_out
);
    always_comb begin
        sources_out = {32{2'b10}};
        sources_out[63] = level_in[0];
        sources_out[32] = level_in[1];
        sources_out[17] = level_in[2];
        sources_out[5] = level_in[3];
    end
endmodule : sources_model

// ### verif/tb_top.sv
// Purpose: Self-checking bench
// Assumes: Selectors written first
// Notes: Rows are levels, masks, control, gates
`timescale 1ns/1ps
module tb_top;
    import cell_gate_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [ADDR_W-1:0] address_in = '0;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [31:0] writedata_in = '0;
    logic [3:0] byteenable_in = 4'hf;
    logic [31:0] readdata_out, q;
    logic waitrequest_out, gate0_out, gate1_out;
    logic cell_data_in_a_out, cell_data_in_b_out, cell_data_in_c_out, cell_data_in_d_out;
    logic [SRC_W-1:0] sources_in;
    logic [3:0] level = 4'h0;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] sv [4] = '{8'hff, 8'h20, 8'h11, 8'hc5};
    logic [29:0] rows [8] = '{{4'h1, 8'h02, 8'h01, 8'h80, 2'b10}, {4'h8, 8'h40, 8'h80, 8'h80, 2'b01},
        {4'hf, 8'h00, 8'h00, 8'h83, 2'b11}, {4'h0, 8'h0c, 8'h30, 8'h80, 2'b11},
        {4'hf, 8'hff, 8'hff, 8'h00, 2'b00}, {4'h6, 8'h01, 8'h40, 8'h80, 2'b11},
        {4'h9, 8'h10, 8'h04, 8'h82, 2'b10}, {4'h4, 8'h08, 8'h20, 8'h81, 2'b11}};
    always #5 clock_in = ~clock_in;
    sources_model i_src (.level_in(level), .sources_out(sources_in));
    logic_cell_input_gating i_dut (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .address_in(address_in),
        .read_in(read_in),
        .write_in(write_in),
        .writedata_in(writedata_in),
        .byteenable_in(byteenable_in),
        .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out),
        .sources_in(sources_in),
        .cell_data_in_a_out(cell_data_in_a_out),
        .cell_data_in_b_out(cell_data_in_b_out),
        .cell_data_in_c_out(cell_data_in_c_out),
        .cell_data_in_d_out(cell_data_in_d_out),
        .gate0_out(gate0_out),
        .gate1_out(gate1_out)
    );
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        address_in <= a;
        writedata_in <= {24'h0, d};
        write_in <= we;
        read_in <= !we;
        // Hold the request until waitrequest is sampled low; the watchdog ends a hang
        do begin
            @(posedge clock_in);
        end while (waitrequest_out !== 1'b0);
        q = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5) @(posedge clock_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 4; i++) bus(1'b1, i[3:0], sv[i]);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, i[3:0], 8'h0);
            chk(q, {24'h0, sv[i] & 8'h3f});
        end
        foreach (rows[i]) begin
            level <= rows[i][29:26];
            bus(1'b1, GATE0_MASK_IDX, rows[i][25:18]);
            bus(1'b1, GATE1_MASK_IDX, rows[i][17:10]);
            bus(1'b1, CONTROL_IDX, rows[i][9:2]);
            repeat (3) @(posedge clock_in);
            chk({cell_data_in_d_out, cell_data_in_c_out, cell_data_in_b_out, cell_data_in_a_out}, level);
            chk({gate0_out, gate1_out}, rows[i][1:0]);
        end
        byteenable_in <= 4'h2;
        bus(1'b1, GATE0_MASK_IDX, 8'h55);
        byteenable_in <= 4'hf;
        bus(1'b0, GATE0_MASK_IDX, 8'h0);
        chk(q, 32'h8);
        bus(1'b0, 4'hf, 8'h0);
        chk(q, 32'h0);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk({gate0_out, gate1_out}, 32'h0);
        resetn_in <= 1'b1;
        bus(1'b0, GATE1_MASK_IDX, 8'h0);
        chk(q, 32'h20);
        bus(1'b0, CONTROL_IDX, 8'h0);
        chk(q, 32'h0);
        bus(1'b1, CONTROL_IDX, 8'hff);
        bus(1'b0, CONTROL_IDX, 8'h0);
        chk(q, {24'h0, CTRL_WMASK});
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge clock_in);
        n_errors++;
        end_sim();
    end
endmodule : tb_top
